/* pkg/pgdis_pkg.sv */
// package: register offsets, field positions and timing for the pg mask / discharge bank
// assumes: 8-bit register port, 20 MHz clock
`default_nettype none
package pgdis_pkg;
	localparam logic [7:0] OFS_MISC_PG   = 8'hac;
	localparam logic [7:0] OFS_TERM_DIS  = 8'had;
	localparam logic [7:0] OFS_AUX_CTRL  = 8'hae;
	// misc power-good mask bit positions
	localparam int OUT1_INPUT3_MASK = 7;
	localparam int OUT1_INPUT6_MASK = 6;
	localparam int OUT4_INPUT3_MASK = 5;
	localparam int OUT4_INPUT6_MASK = 4;
	localparam int OUT2_INPUT3_MASK = 3;
	localparam int OUT2_INPUT6_MASK = 2;
	localparam int OUT3_INPUT3_MASK = 1;
	localparam int OUT3_INPUT6_MASK = 0;
	// termination discharge select
	localparam int TERM_DISCHARGE_SEL = 4;
	// aux ldo register fields
	localparam int AUX_DIS_HI      = 7;
	localparam int AUX_DIS_LO      = 6;
	localparam int AUX_SHUTDOWN    = 5;
	localparam int AUX_VCODE_HI    = 4;
	localparam int AUX_VCODE_LO    = 1;
	localparam int AUX_ENABLE      = 0;
	// discharge resistance codes
	localparam logic [1:0] DIS_NONE = 2'h0;
	localparam logic [1:0] DIS_100  = 2'h1;
	localparam logic [1:0] DIS_200  = 2'h2;
	localparam logic [1:0] DIS_500  = 2'h3;
	// shutdown off period choices in ms, code chosen by otp
	localparam int OFF_MS_0 = 1;
	localparam int OFF_MS_1 = 5;
	localparam int OFF_MS_2 = 10;
	localparam int OFF_MS_3 = 100;
	localparam int CLK_HZ   = 20000000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
endpackage
`default_nettype wire

/* rtl/off_timer.sv */
// off-period timer: counts whole milliseconds from a one-cycle start pulse
// assumes: ms_tick is a one-cycle enable from the caller's divider
`default_nettype none
module off_timer #(
	parameter int MAX_MS = 100
) (
	input  wire logic       clk,      // system clock
	input  wire logic       rst,      // sync reset, high
	input  wire logic       start,    // begin an off period
	input  wire logic       ms_tick,  // one pulse per millisecond
	input  wire logic [6:0] len_ms,   // period length in ms
	output logic            busy      // high while the period runs
);
	// the count register is seven bits wide, so longer periods cannot be served
	if (MAX_MS < 1 || MAX_MS > 127) begin : g_bad_max
		$error("off_timer: MAX_MS out of range");
	end

	logic [6:0] left_ff;

	// restart wins over a running count
	always_ff @(posedge clk) begin
		if (rst) begin
			left_ff <= 7'h00;
		end else if (start) begin
			left_ff <= len_ms;
		end else if (ms_tick && left_ff != 7'h00) begin
			left_ff <= left_ff - 7'h01;
		end
	end

	assign busy = (left_ff != 7'h00);
endmodule
`default_nettype wire

/* rtl/pg_mask_discharge_ctrl_regs.sv */
// pg mask, termination discharge and aux ldo control registers with the logic they steer
// assumes: an 8-bit register port from the serial control block, otp values and raw pins
// Function
// [R1] misc bits 7,6 drop input 3 / input 6 from output 1 tree
// [R2] misc bits 5,4 drop input 3 / input 6 from output 4 tree
// [R3] misc bits 3,2 drop input 3 / input 6 from output 2 tree
// [R4] misc bits 1,0 drop input 3 / input 6 from output 3 tree
// [R5] termination bit 4: 0 no discharge, 1 selects 100 ohm path
// [R6] software writes reserved termination bits matching otp contents
// [R7] aux bits 7:6 choose discharge: none, 100, 200, 500 ohm
// [R8] shutdown-config 0: emergency shutdown turns aux off for otp period
// [R9] shutdown-config 1: aux follows only its enable bit
// [R10] sequenced aux ldo with unmerged b switches: control acts on switch b2
// [R11] aux bits 4:1 give the aux ldo output voltage code
// [R12] aux bit 0 enables ldo or switch b2 as otp selects
// [R13] reset loads all three registers from otp
// [R14] pg output asserts only when all unmasked inputs are good
`default_nettype none
module pg_mask_discharge_ctrl_regs (
	input  wire logic       clk,               // 20 MHz clock
	input  wire logic       rst,               // sync reset, high
	input  wire logic [7:0] reg_addr,          // register offset
	input  wire logic [7:0] reg_wdata,         // write data
	input  wire logic       reg_wr,            // write strobe
	output logic [7:0]      reg_rdata,         // read data, zero when unmapped
	input  wire logic [7:0] otp_misc_pg,       // otp reset value, mask register
	input  wire logic [7:0] otp_term_dis,      // otp reset value, termination register
	input  wire logic [7:0] otp_aux_ctrl,      // otp reset value, aux register
	input  wire logic [1:0] otp_off_sel,       // otp choice of off period
	input  wire logic       otp_aux_is_switch, // otp: aux output is load switch b2
	input  wire logic       otp_aux_in_seq,    // otp: aux ldo used in sequence
	input  wire logic       otp_b_merged,      // otp: switches b1 and b2 merged
	input  wire logic       control_input_3,   // pin, asynchronous
	input  wire logic       control_input_6,   // pin, asynchronous
	input  wire logic [3:0] tree_good,         // other pg sources per output, already masked
	input  wire logic       emergency_sd,      // emergency shutdown level, same domain
	output logic            pg_output_1,       // power good 1
	output logic            pg_output_2,       // power good 2
	output logic            pg_output_3,       // power good 3
	output logic            pg_output_4,       // power good 4
	output logic            termination_discharge_sel, // 100 ohm path on
	output logic [1:0]      aux_ldo_discharge_sel,     // discharge code
	output logic [3:0]      aux_ldo_voltage_code,      // voltage code
	output logic            aux_ldo_1_on,      // aux ldo enabled
	output logic            load_switch_b2_on  // switch b2 enabled
);
	logic [7:0] misc_ff;
	logic [7:0] term_ff;
	logic [7:0] aux_ff;
	logic [1:0] c3_sync_ff;
	logic [1:0] c6_sync_ff;
	logic [3:0] pg_ff;
	logic       sd_prev_ff;
	logic [14:0] div_ff;
	logic       ms_tick;
	logic       sd_start;
	logic       off_busy;
	logic [6:0] off_len;
	logic       aux_gate;
	logic       to_switch;
	logic       wr_misc;
	logic       wr_term;
	logic       wr_aux;
	logic [3:0] nxt_pg;

	// one tree: good when each input is either masked or high
	function automatic logic tree(input logic others, input logic m3, input logic m6,
		input logic i3, input logic i6);
		tree = others & (m3 | i3) & (m6 | i6);
	endfunction

	// write decode
	assign wr_misc = reg_wr && reg_addr == pgdis_pkg::OFS_MISC_PG;
	assign wr_term = reg_wr && reg_addr == pgdis_pkg::OFS_TERM_DIS;
	assign wr_aux  = reg_wr && reg_addr == pgdis_pkg::OFS_AUX_CTRL;

	// [R13] otp reset load
	// the reserved termination bits are stored as written; keeping them equal to otp is
	// software's duty, so hardware does not force them back
	always_ff @(posedge clk) begin
		if (rst) begin
			misc_ff <= otp_misc_pg;
			term_ff <= otp_term_dis;
			aux_ff  <= otp_aux_ctrl;
		end else begin
			if (wr_misc) misc_ff <= reg_wdata;
			if (wr_term) term_ff <= reg_wdata;
			if (wr_aux)  aux_ff  <= reg_wdata;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		case (reg_addr)
			pgdis_pkg::OFS_MISC_PG:  reg_rdata = misc_ff;
			pgdis_pkg::OFS_TERM_DIS: reg_rdata = term_ff;
			pgdis_pkg::OFS_AUX_CTRL: reg_rdata = aux_ff;
			default:                 reg_rdata = 8'h00;
		endcase
	end

	// pin synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			c3_sync_ff <= 2'h0;
			c6_sync_ff <= 2'h0;
		end else begin
			c3_sync_ff <= {c3_sync_ff[0], control_input_3};
			c6_sync_ff <= {c6_sync_ff[0], control_input_6};
		end
	end

	// [R14] power good trees
	// [R1] output 1 masks
	assign nxt_pg[0] = tree(tree_good[0], misc_ff[pgdis_pkg::OUT1_INPUT3_MASK],
		misc_ff[pgdis_pkg::OUT1_INPUT6_MASK], c3_sync_ff[1], c6_sync_ff[1]);
	// [R3] output 2 masks
	assign nxt_pg[1] = tree(tree_good[1], misc_ff[pgdis_pkg::OUT2_INPUT3_MASK],
		misc_ff[pgdis_pkg::OUT2_INPUT6_MASK], c3_sync_ff[1], c6_sync_ff[1]);
	// [R4] output 3 masks
	assign nxt_pg[2] = tree(tree_good[2], misc_ff[pgdis_pkg::OUT3_INPUT3_MASK],
		misc_ff[pgdis_pkg::OUT3_INPUT6_MASK], c3_sync_ff[1], c6_sync_ff[1]);
	// [R2] output 4 masks
	assign nxt_pg[3] = tree(tree_good[3], misc_ff[pgdis_pkg::OUT4_INPUT3_MASK],
		misc_ff[pgdis_pkg::OUT4_INPUT6_MASK], c3_sync_ff[1], c6_sync_ff[1]);

	// registered so outputs do not glitch while masks change
	always_ff @(posedge clk) begin
		if (rst) pg_ff <= 4'h0;
		else     pg_ff <= nxt_pg;
	end
	assign pg_output_1 = pg_ff[0];
	assign pg_output_2 = pg_ff[1];
	assign pg_output_3 = pg_ff[2];
	assign pg_output_4 = pg_ff[3];

	// [R5] termination discharge
	assign termination_discharge_sel = term_ff[pgdis_pkg::TERM_DISCHARGE_SEL];
	// [R7] aux discharge code
	assign aux_ldo_discharge_sel = aux_ff[pgdis_pkg::AUX_DIS_HI:pgdis_pkg::AUX_DIS_LO];
	// [R11] voltage code
	assign aux_ldo_voltage_code = aux_ff[pgdis_pkg::AUX_VCODE_HI:pgdis_pkg::AUX_VCODE_LO];

	// millisecond divider
	assign ms_tick = (div_ff == 15'(pgdis_pkg::CYC_PER_MS - 1));
	always_ff @(posedge clk) begin
		if (rst || ms_tick) div_ff <= 15'h0000;
		else                div_ff <= div_ff + 15'h0001;
	end

	// shutdown edge starts the off period
	always_ff @(posedge clk) begin
		if (rst) sd_prev_ff <= 1'b0;
		else     sd_prev_ff <= emergency_sd;
	end
	// [R8] off period only when config bit clear
	assign sd_start = emergency_sd && !sd_prev_ff && !aux_ff[pgdis_pkg::AUX_SHUTDOWN];

	// otp picks one of four lengths
	always_comb begin
		case (otp_off_sel)
			2'h0:    off_len = 7'(pgdis_pkg::OFF_MS_0);
			2'h1:    off_len = 7'(pgdis_pkg::OFF_MS_1);
			2'h2:    off_len = 7'(pgdis_pkg::OFF_MS_2);
			default: off_len = 7'(pgdis_pkg::OFF_MS_3);
		endcase
	end

	off_timer #(.MAX_MS(pgdis_pkg::OFF_MS_3)) u_off (
		.clk     (clk),
		.rst     (rst),
		.start   (sd_start),
		.ms_tick (ms_tick),
		.len_ms  (off_len),
		.busy    (off_busy)
	);

	// [R9] with config bit set, only the enable bit counts
	// [R12] enable bit drives the chosen output
	assign aux_gate = aux_ff[pgdis_pkg::AUX_ENABLE] &&
		(aux_ff[pgdis_pkg::AUX_SHUTDOWN] || !off_busy);
	// [R10] sequenced ldo with unmerged switches: control goes to b2
	assign to_switch = otp_aux_is_switch || (otp_aux_in_seq && !otp_b_merged);
	assign aux_ldo_1_on = aux_gate && !to_switch;
	assign load_switch_b2_on = aux_gate && to_switch;

	// [R1] output 1 follows an unmasked input 3 being low
	AST_OUT1_MASK3: assert property (@(posedge clk) disable iff (rst) // [R1]
		(misc_ff[pgdis_pkg::OUT1_INPUT3_MASK] == 1'b0 && c3_sync_ff[1] == 1'b0)
		|=> !pg_output_1)
		else $error("output 1 high with unmasked input 3 low");
	AST_OUT4_MASK6: assert property (@(posedge clk) disable iff (rst) // [R2]
		(!misc_ff[pgdis_pkg::OUT4_INPUT6_MASK] && !c6_sync_ff[1]) |=> !pg_output_4)
		else $error("output 4 high with unmasked input 6 low");
	AST_OUT2_ALLMASK: assert property (@(posedge clk) disable iff (rst) // [R3]
		(misc_ff[pgdis_pkg::OUT2_INPUT3_MASK] && misc_ff[pgdis_pkg::OUT2_INPUT6_MASK])
		|=> pg_output_2 == $past(tree_good[1]))
		else $error("output 2 not equal to other sources with both masked");
	AST_OUT3_GOOD: assert property (@(posedge clk) disable iff (rst) // [R4]
		(tree_good[2] && c3_sync_ff[1] && c6_sync_ff[1]) |=> pg_output_3)
		else $error("output 3 low with all inputs good");
	AST_TERM_DIS: assert property (@(posedge clk) disable iff (rst) // [R5]
		wr_term |=> termination_discharge_sel ==
		$past(reg_wdata[pgdis_pkg::TERM_DISCHARGE_SEL]))
		else $error("termination discharge did not follow write");
	AST_AUX_DIS: assert property (@(posedge clk) disable iff (rst) // [R7]
		wr_aux |=> aux_ldo_discharge_sel ==
		$past(reg_wdata[pgdis_pkg::AUX_DIS_HI:pgdis_pkg::AUX_DIS_LO]))
		else $error("aux discharge code did not follow write");
	AST_SD_OFF: assert property (@(posedge clk) disable iff (rst) // [R8]
		sd_start |=> aux_ff[pgdis_pkg::AUX_SHUTDOWN] || (!aux_ldo_1_on && !load_switch_b2_on))
		else $error("aux output stayed on after shutdown");
	AST_SD_IGNORE: assert property (@(posedge clk) disable iff (rst) // [R9]
		aux_ff[pgdis_pkg::AUX_SHUTDOWN] |->
		((aux_ldo_1_on || load_switch_b2_on) == aux_ff[pgdis_pkg::AUX_ENABLE]))
		else $error("aux output not following enable bit");
	AST_ROUTE: assert property (@(posedge clk) disable iff (rst) // [R10]
		(otp_aux_in_seq && !otp_b_merged) |-> !aux_ldo_1_on)
		else $error("control routed to ldo instead of switch b2");
	AST_VCODE: assert property (@(posedge clk) disable iff (rst) // [R11]
		wr_aux |=> aux_ldo_voltage_code ==
		$past(reg_wdata[pgdis_pkg::AUX_VCODE_HI:pgdis_pkg::AUX_VCODE_LO]))
		else $error("voltage code did not follow write");
	AST_EN_OFF: assert property (@(posedge clk) disable iff (rst) // [R12]
		!aux_ff[pgdis_pkg::AUX_ENABLE] |-> !aux_ldo_1_on && !load_switch_b2_on)
		else $error("aux output on while disabled");
	AST_OTP_LOAD: assert property (@(posedge clk) // [R13]
		rst |=> misc_ff == $past(otp_misc_pg) && term_ff == $past(otp_term_dis) &&
		aux_ff == $past(otp_aux_ctrl))
		else $error("registers not loaded from otp");
	AST_PG_ALL: assert property (@(posedge clk) disable iff (rst) // [R14]
		!tree_good[0] |=> !pg_output_1)
		else $error("output 1 high with other source bad");
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the pg mask / discharge register bank, model compared at each result
// assumes: package and design compiled first; one 20 MHz clock, inputs driven at falling edges
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic [7:0]  reg_rdata;
	logic [7:0]  otp_misc_pg = 8'h00;
	logic [7:0]  otp_term_dis = 8'h00;
	logic [7:0]  otp_aux_ctrl = 8'h00;
	logic [1:0]  otp_off_sel = 2'h0;
	logic [2:0]  cfg = 3'h0;
	logic        ci3 = 1'b0;
	logic        ci6 = 1'b0;
	logic [3:0]  tree_good = 4'h0;
	logic        emergency_sd = 1'b0;
	logic [3:0]  pg;
	logic        term_sel;
	logic [1:0]  dis_sel;
	logic [3:0]  vcode;
	logic        ldo_on;
	logic        b2_on;
	logic [7:0]  m_mask, m_term, m_aux;
	logic [31:0] seed = 32'he4143273;
	logic [31:0] s;
	int          failures = 0;
	int          n_checks = 0;

	pg_mask_discharge_ctrl_regs DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
		.otp_misc_pg(otp_misc_pg), .otp_term_dis(otp_term_dis), .otp_aux_ctrl(otp_aux_ctrl),
		.otp_off_sel(otp_off_sel), .otp_aux_is_switch(cfg[2]), .otp_aux_in_seq(cfg[1]),
		.otp_b_merged(cfg[0]), .control_input_3(ci3), .control_input_6(ci6),
		.tree_good(tree_good), .emergency_sd(emergency_sd), .pg_output_1(pg[0]),
		.pg_output_2(pg[1]), .pg_output_3(pg[2]), .pg_output_4(pg[3]),
		.termination_discharge_sel(term_sel), .aux_ldo_discharge_sel(dis_sel),
		.aux_ldo_voltage_code(vcode), .aux_ldo_1_on(ldo_on), .load_switch_b2_on(b2_on));

	// 50 ns period
	always #25 clk = ~clk;

	// xorshift source, fixed start so runs repeat
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// each output's tree: unmasked pins and the other sources must all be good
	function automatic logic [3:0] pg_model(logic [7:0] m, logic [3:0] tg, logic c3, logic c6);
		pg_model[0] = tg[0] & (m[7] | c3) & (m[6] | c6);
		pg_model[1] = tg[1] & (m[3] | c3) & (m[2] | c6);
		pg_model[2] = tg[2] & (m[1] | c3) & (m[0] | c6);
		pg_model[3] = tg[3] & (m[5] | c3) & (m[4] | c6);
	endfunction

	// {ldo on, switch b2 on}; b2 takes the control when otp says so
	function automatic logic [1:0] aux_model(logic en, logic off);
		logic sw;
		sw = cfg[2] | (cfg[1] & ~cfg[0]);
		return {~sw & en & ~off, sw & en & ~off};
	endfunction

	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t register value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t output pins %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// read is combinational, looked at one falling edge after the address is set
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		chk_reg(reg_rdata, exp);
	endtask

	task automatic rd_all();
		rd(pgdis_pkg::OFS_MISC_PG, m_mask);
		rd(pgdis_pkg::OFS_TERM_DIS, m_term);
		rd(pgdis_pkg::OFS_AUX_CTRL, m_aux);
	endtask

	task automatic chk_all(input logic off);
		chk_pin(pg, pg_model(m_mask, tree_good, ci3, ci6));
		chk_reg({term_sel, dis_sel, vcode, 1'b0}, {m_term[4], m_aux[7:6], m_aux[4:1], 1'b0});
		chk_pin({2'b00, ldo_on, b2_on}, {2'b00, aux_model(m_aux[0], off)});
	endtask

	// hang guard: well past the longest sequence, still inside the cycle budget
	initial begin
		#3ms;
		failures++;
		end_of_test();
	end

	initial begin
		s = rnd();
		otp_misc_pg = s[7:0];
		otp_term_dis = s[15:8];
		otp_aux_ctrl = s[23:16];
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		m_mask = otp_misc_pg;
		m_term = otp_term_dis;
		m_aux = otp_aux_ctrl;
		rd_all();
		rd(8'haf, 8'h00);
		rd(8'h00, 8'h00);
		// random masks, pins and fields; shutdown stays quiet here
		for (int i = 0; i < 32; i++) begin
			s = rnd();
			m_mask = s[7:0];
			// reserved bits rewritten with the otp contents
			m_term = (otp_term_dis & 8'hef) | {3'b000, s[8], 4'h0};
			m_aux = s[23:16];
			{ci3, ci6, tree_good, cfg} = s[31:23];
			wr(pgdis_pkg::OFS_MISC_PG, m_mask);
			wr(pgdis_pkg::OFS_TERM_DIS, m_term);
			wr(pgdis_pkg::OFS_AUX_CTRL, m_aux);
			repeat (4) @(negedge clk);
			chk_all(1'b0);
		end
		rd_all();
		// unmapped write leaves all three untouched
		s = rnd();
		wr(8'haf, s[7:0]);
		rd_all();
		// every routing choice of the aux control
		for (int i = 0; i < 8; i++) begin
			cfg = i[2:0];
			m_aux = {i[1:0], 6'h01};
			wr(pgdis_pkg::OFS_AUX_CTRL, m_aux);
			chk_all(1'b0);
		end
		// shutdown-config 0: output dropped for the 1 ms period, then back
		otp_off_sel = 2'h0;
		m_aux = 8'h01;
		wr(pgdis_pkg::OFS_AUX_CTRL, m_aux);
		emergency_sd = 1'b1;
		repeat (2) @(negedge clk);
		chk_all(1'b1);
		emergency_sd = 1'b0;
		repeat (pgdis_pkg::CYC_PER_MS + 100) @(negedge clk);
		chk_all(1'b0);
		// shutdown-config 1: enable bit alone decides
		m_aux = 8'h21;
		wr(pgdis_pkg::OFS_AUX_CTRL, m_aux);
		emergency_sd = 1'b1;
		repeat (2) @(negedge clk);
		chk_all(1'b0);
		emergency_sd = 1'b0;
		// longer otp period: still off after one ms, then cut short by a reset
		s = rnd();
		otp_off_sel = (s[1:0] == 2'h0) ? 2'h1 : s[1:0];
		m_aux = 8'h01;
		wr(pgdis_pkg::OFS_AUX_CTRL, m_aux);
		emergency_sd = 1'b1;
		repeat (2) @(negedge clk);
		emergency_sd = 1'b0;
		repeat (pgdis_pkg::CYC_PER_MS + 100) @(negedge clk);
		chk_all(1'b1);
		// second reset mid-run: new otp contents load and the timer is cleared
		s = rnd();
		otp_misc_pg = s[7:0];
		otp_term_dis = s[15:8];
		otp_aux_ctrl = s[23:16];
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		m_mask = otp_misc_pg;
		m_term = otp_term_dis;
		m_aux = otp_aux_ctrl;
		rd_all();
		chk_all(1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
